//--- rtl/hmcg_halt_ctrl.sv
// Purpose: Pause-state controller gating the CPU clock enable.
// Assumes: halt_exec is a one-cycle pulse from instruction decode.
// Notes: Peripheral enables never depend on the pause state.
`include "hmcg_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Pause entered only by pause instruction.
// - Entry allowed from any CPU clock source.
// - Timer H1 guaranteed only on internal/128.
// - Counter 51 guaranteed only on external input.
// - Timer H0 guaranteed only counting counter 50.
module hmcg_halt_ctrl #(
	parameter int unsigned INT_DIV = `HMCG_INT_DIV,
	parameter int unsigned SUB_DIV = `HMCG_SUB_DIV
) (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// CPU side.
	input  wire logic       halt_exec,
	input  wire logic       wake_req,
	input  wire logic [1:0] cpu_clk_sel,
	// Oscillator run levels.
	input  wire logic       hs_osc_run,
	input  wire logic       int_osc_run,
	input  wire logic       sub_osc_run,
	// Timer count clock selections and sources.
	input  wire logic [2:0] tmh1_clk_sel,
	input  wire logic [2:0] cnt51_clk_sel,
	input  wire logic [2:0] tmh0_clk_sel,
	input  wire logic       counter51_external_count_input,
	input  wire logic       counter50_output,
	input  wire logic       counter50_running,
	// Clock enables.
	output logic            cpu_clk_en,
	output logic            tmh1_clk_en,
	output logic            cnt51_clk_en,
	output logic            tmh0_clk_en,
	// Status.
	output logic            halt_active,
	output logic            tmh1_op_ok,
	output logic            cnt51_op_ok,
	output logic            tmh0_op_ok
);

	hmcg_pkg::hmcg_state_t state_reg;
	hmcg_pkg::hmcg_state_t state_next;
	logic                  cpu_en_reg;
	logic                  cpu_en_next;
	logic                  tmh1_en_reg;
	logic                  tmh1_en_next;
	logic                  cnt51_en_reg;
	logic                  cnt51_en_next;
	logic                  tmh0_en_reg;
	logic                  tmh0_en_next;
	logic                  ext51_reg;
	logic                  ext51_next;
	logic                  c50_reg;
	logic                  c50_next;
	logic                  hs_tick;
	logic                  int_tick;
	logic                  int_div_tick;
	logic                  sub_tick;
	logic                  src_tick;
	logic                  hs_stopped;
	logic                  sel_tmh1_ok;
	logic                  sel_cnt51_ok;
	logic                  sel_tmh0_ok;

	hmcg_clk_div #(
		.HS_DIV  (`HMCG_HS_DIV),
		.INT_DIV (INT_DIV),
		.SUB_DIV (SUB_DIV)
	) u_div (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.hs_run       (hs_osc_run),
		.int_run      (int_osc_run),
		.sub_run      (sub_osc_run),
		.hs_tick      (hs_tick),
		.int_tick     (int_tick),
		.int_div_tick (int_div_tick),
		.sub_tick     (sub_tick)
	);

	// Pause state sequencing.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hmcg_pkg::st_run: begin
				if (halt_exec) begin
					state_next = hmcg_pkg::st_halt;
				end
			end
			hmcg_pkg::st_halt: begin
				if (wake_req) begin
					state_next = hmcg_pkg::st_run;
				end
			end
			default: begin
				state_next = hmcg_pkg::st_run;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= hmcg_pkg::st_run;
		end else begin
			state_reg <= state_next;
		end
	end

	// Clock source and guarantee decoding.
	always_comb begin
		if (cpu_clk_sel == 2'(hmcg_pkg::src_internal)) begin
			src_tick = int_tick;
		end else if (cpu_clk_sel == 2'(hmcg_pkg::src_subsystem)) begin
			src_tick = sub_tick;
		end else begin
			src_tick = hs_tick;
		end
		hs_stopped   = !hs_osc_run;
		sel_tmh1_ok  = (tmh1_clk_sel == `HMCG_TMH1_SEL_INT_DIV);
		sel_cnt51_ok = (cnt51_clk_sel == `HMCG_CNT51_SEL_EXT);
		sel_tmh0_ok  = (tmh0_clk_sel == `HMCG_TMH0_SEL_CNT50) && counter50_running;
	end

	// Clock enable generation.
	always_comb begin
		ext51_next    = counter51_external_count_input;
		c50_next      = counter50_output;
		cpu_en_next   = src_tick && (state_next == hmcg_pkg::st_run);
		tmh1_en_next  = sel_tmh1_ok ? int_div_tick : hs_tick;
		cnt51_en_next = sel_cnt51_ok ? (counter51_external_count_input && !ext51_reg) : hs_tick;
		tmh0_en_next  = sel_tmh0_ok ? (counter50_output && !c50_reg) : hs_tick;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cpu_en_reg   <= `HMCG_EN_RESET;
			tmh1_en_reg  <= `HMCG_EN_RESET;
			cnt51_en_reg <= `HMCG_EN_RESET;
			tmh0_en_reg  <= `HMCG_EN_RESET;
			ext51_reg    <= 1'b0;
			c50_reg      <= 1'b0;
		end else begin
			cpu_en_reg   <= cpu_en_next;
			tmh1_en_reg  <= tmh1_en_next;
			cnt51_en_reg <= cnt51_en_next;
			tmh0_en_reg  <= tmh0_en_next;
			ext51_reg    <= ext51_next;
			c50_reg      <= c50_next;
		end
	end

	assign cpu_clk_en   = cpu_en_reg;
	assign tmh1_clk_en  = tmh1_en_reg;
	assign cnt51_clk_en = cnt51_en_reg;
	assign tmh0_clk_en  = tmh0_en_reg;
	assign halt_active  = (state_reg == hmcg_pkg::st_halt);
	assign tmh1_op_ok   = !(halt_active && hs_stopped) || sel_tmh1_ok;
	assign cnt51_op_ok  = !(halt_active && hs_stopped) || sel_cnt51_ok;
	assign tmh0_op_ok   = !(halt_active && hs_stopped) || sel_tmh0_ok;

	// Checks.
	sequence s_run_halt;
		!halt_active && halt_exec;
	endsequence

	sequence s_halted;
		halt_active && !wake_req;
	endsequence

	chk_halt_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_run_halt |=> halt_active)
		else $error("Pause instruction did not enter the pause state.");

	chk_entry_only_instr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!halt_active && !halt_exec |=> !halt_active)
		else $error("Pause state entered without the pause instruction.");

	chk_any_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_run_halt ##1 s_halted |=> halt_active && !cpu_clk_en)
		else $error("Pause entry refused or CPU clock not gated.");

	chk_cpu_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_halted |=> !cpu_clk_en)
		else $error("CPU clock enable pulsed during the pause state.");

	chk_tmh1_runs: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_active && sel_tmh1_ok && int_div_tick |=> tmh1_clk_en)
		else $error("Timer H1 lost its internal divided clock while paused.");

	chk_tmh1_guarantee: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_active && hs_stopped && !sel_tmh1_ok |-> !tmh1_op_ok)
		else $error("Timer H1 guarantee wrong with high speed stopped.");

	chk_cnt51_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sel_cnt51_ok && $rose(counter51_external_count_input) |=> cnt51_clk_en)
		else $error("Counter 51 missed an external count edge.");

	chk_cnt51_guarantee: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_active && hs_stopped |-> cnt51_op_ok == sel_cnt51_ok)
		else $error("Counter 51 guarantee wrong with high speed stopped.");

	chk_tmh0_cnt50: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sel_tmh0_ok && $rose(counter50_output) |=> tmh0_clk_en)
		else $error("Timer H0 missed a counter 50 output edge.");

	chk_tmh0_guarantee: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_active && hs_stopped |-> tmh0_op_ok == sel_tmh0_ok)
		else $error("Timer H0 guarantee wrong with high speed stopped.");

	chk_periph_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
		halt_active && !sel_tmh1_ok && hs_tick |=> tmh1_clk_en)
		else $error("Peripheral clock stopped by the pause state.");

endmodule // hmcg_halt_ctrl

`default_nettype wire

//--- rtl/hmcg_params.svh
// Purpose: Constants for the pause-state clock gating block.
// Assumes: ref_clk at 250 MHz; source rates are modelled as enable pulses.
// Notes: Selection codes are local encodings of the timer clock selects.
`ifndef HMCG_PARAMS_SVH
`define HMCG_PARAMS_SVH

// Reference clock period and source oscillator periods, in ns.
`define HMCG_REF_PERIOD_NS  4
`define HMCG_HS_PERIOD_NS   100
`define HMCG_INT_PERIOD_NS  4000
`define HMCG_SUB_PERIOD_NS  30518

// Longest-time counts, rounded down, never below one cycle.
`define HMCG_HS_DIV   (`HMCG_HS_PERIOD_NS / `HMCG_REF_PERIOD_NS)
`define HMCG_INT_DIV  (`HMCG_INT_PERIOD_NS / `HMCG_REF_PERIOD_NS)
`define HMCG_SUB_DIV  (`HMCG_SUB_PERIOD_NS / `HMCG_REF_PERIOD_NS)

// Internal oscillator prescaler exponent for the second interval timer.
`define HMCG_INT_PRESC_EXP  7

// Count clock selection codes.
`define HMCG_TMH1_SEL_INT_DIV  3'h5
`define HMCG_CNT51_SEL_EXT     3'h0
`define HMCG_TMH0_SEL_CNT50    3'h6

// Reset values of registered enables.
`define HMCG_EN_RESET  1'b0

`endif

//--- rtl/hmcg_pkg.sv
// Purpose: Types for the pause-state clock gating block.
// Assumes: Nothing beyond the parameter header.
// Notes: Used by scope, never imported.
package hmcg_pkg;

	typedef enum logic {
		st_run,
		st_halt
	} hmcg_state_t;

	typedef enum logic [1:0] {
		src_high_speed,
		src_internal,
		src_subsystem
	} hmcg_src_t;

endpackage

//--- rtl/hmcg_clk_div.sv
// Purpose: Enable-pulse dividers standing in for the three oscillators.
// Assumes: Each divisor is at least one.
// Notes: A stopped oscillator yields no pulses.
`include "hmcg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module hmcg_clk_div #(
	parameter int unsigned HS_DIV  = `HMCG_HS_DIV,
	parameter int unsigned INT_DIV = `HMCG_INT_DIV,
	parameter int unsigned SUB_DIV = `HMCG_SUB_DIV
) (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Oscillator run levels.
	input  wire logic hs_run,
	input  wire logic int_run,
	input  wire logic sub_run,
	// Source enable pulses.
	output logic      hs_tick,
	output logic      int_tick,
	output logic      int_div_tick,
	output logic      sub_tick
);

	logic [15:0] hs_cnt_reg;
	logic [15:0] hs_cnt_next;
	logic [15:0] int_cnt_reg;
	logic [15:0] int_cnt_next;
	logic [15:0] sub_cnt_reg;
	logic [15:0] sub_cnt_next;
	logic [`HMCG_INT_PRESC_EXP-1:0] presc_reg;
	logic [`HMCG_INT_PRESC_EXP-1:0] presc_next;

	// Advances a divider counter and wraps at the divisor.
	function automatic logic [15:0] div_step(input logic [15:0] cnt, input int unsigned div, input logic run);
		logic [15:0] last;
		last = 16'(div - 1);
		if (!run) begin
			div_step = cnt;
		end else if (cnt >= last) begin
			div_step = 16'h0000;
		end else begin
			div_step = cnt + 16'h0001;
		end
	endfunction

	always_comb begin
		hs_cnt_next  = div_step(hs_cnt_reg, HS_DIV, hs_run);
		int_cnt_next = div_step(int_cnt_reg, INT_DIV, int_run);
		sub_cnt_next = div_step(sub_cnt_reg, SUB_DIV, sub_run);
		presc_next   = int_tick ? presc_reg + 1'b1 : presc_reg;
		hs_tick      = hs_run && (hs_cnt_reg == 16'(HS_DIV - 1));
		int_tick     = int_run && (int_cnt_reg == 16'(INT_DIV - 1));
		sub_tick     = sub_run && (sub_cnt_reg == 16'(SUB_DIV - 1));
		int_div_tick = int_tick && (&presc_reg);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hs_cnt_reg  <= 16'h0000;
			int_cnt_reg <= 16'h0000;
			sub_cnt_reg <= 16'h0000;
			presc_reg   <= '0;
		end else begin
			hs_cnt_reg  <= hs_cnt_next;
			int_cnt_reg <= int_cnt_next;
			sub_cnt_reg <= sub_cnt_next;
			presc_reg   <= presc_next;
		end
	end

endmodule // hmcg_clk_div

`default_nettype wire

//--- verification/tb_halt_mode_clock_gating.sv
// Purpose: Self-checking bench for the pause-state clock gating controller.
// Assumes: Inputs change on the falling edge; SUB_DIV is shortened to 5 and INT_DIV to 4.
// Notes: A monitor checks pause changes and count pulses against queued notes.
`include "hmcg_params.svh"
`timescale 1ns/1ps
`default_nettype none

`define TB_CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin n_errors++; $display("BAD %0t %s", $time, msg); end end

module tb_halt_mode_clock_gating;
	localparam int unsigned SUB_DIV = 5;
	localparam int unsigned INT_DIV = 4;
	logic       ref_clk, rst_n, halt_exec, wake_req, hs_osc_run, int_osc_run, sub_osc_run;
	logic [1:0] cpu_clk_sel;
	logic [2:0] tmh1_clk_sel, cnt51_clk_sel, tmh0_clk_sel, t;
	logic       ext_in, c50_out, c50_run, prev_halt;
	logic       cpu_clk_en, tmh1_clk_en, cnt51_clk_en, tmh0_clk_en;
	logic       halt_active, tmh1_op_ok, cnt51_op_ok, tmh0_op_ok;
	logic       q_halt[$];
	logic [1:0] q_pulse[$];
	int         n_errors, total_checks, n_cpu, n_tmh1, base, base1;

	hmcg_halt_ctrl #(.INT_DIV(INT_DIV), .SUB_DIV(SUB_DIV)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .halt_exec(halt_exec), .wake_req(wake_req),
		.cpu_clk_sel(cpu_clk_sel), .hs_osc_run(hs_osc_run), .int_osc_run(int_osc_run),
		.sub_osc_run(sub_osc_run), .tmh1_clk_sel(tmh1_clk_sel), .cnt51_clk_sel(cnt51_clk_sel),
		.tmh0_clk_sel(tmh0_clk_sel), .counter51_external_count_input(ext_in),
		.counter50_output(c50_out), .counter50_running(c50_run), .cpu_clk_en(cpu_clk_en),
		.tmh1_clk_en(tmh1_clk_en), .cnt51_clk_en(cnt51_clk_en), .tmh0_clk_en(tmh0_clk_en),
		.halt_active(halt_active), .tmh1_op_ok(tmh1_op_ok), .cnt51_op_ok(cnt51_op_ok),
		.tmh0_op_ok(tmh0_op_ok)
	);

	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic pop_pulse(input logic [1:0] code);
		if (q_pulse.size() == 0) `TB_CHK(code, 2'd0, "unexpected count pulse")
		else `TB_CHK(code, q_pulse.pop_front(), "count pulse source")
	endtask

	// The monitor compares every pause change and external count pulse with the oldest note.
	always @(negedge ref_clk) begin
		if (rst_n === 1'b1) begin
			if (halt_active !== prev_halt) begin
				if (q_halt.size() == 0) `TB_CHK(halt_active, prev_halt, "unexpected pause change")
				else `TB_CHK(halt_active, q_halt.pop_front(), "pause state")
			end
			if (cnt51_clk_en === 1'b1) pop_pulse(2'd1);
			if (tmh0_clk_en === 1'b1) pop_pulse(2'd2);
			if (cpu_clk_en === 1'b1) n_cpu++;
			if (tmh1_clk_en === 1'b1) n_tmh1++;
		end
		prev_halt = halt_active;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wait_cpu(input int bound);
		int start;
		start = n_cpu;
		for (int i = 0; i < bound && n_cpu == start; i++) cyc(1);
		if (n_cpu == start) begin
			n_errors++;
			$display("BAD %0t CPU clock enable never came", $time);
			print_verdict();
		end
	endtask

	task automatic enter_halt();
		halt_exec = 1'b1;
		q_halt.push_back(1'b1);
		cyc(1);
		halt_exec = 1'b0;
	endtask

	task automatic leave_halt();
		wake_req = 1'b1;
		q_halt.push_back(1'b0);
		cyc(1);
		wake_req = 1'b0;
	endtask

	task automatic rise(input logic [1:0] code);
		q_pulse.push_back(code);
		if (code == 2'd1) ext_in = 1'b1;
		else c50_out = 1'b1;
		cyc(4);
		ext_in = 1'b0;
		c50_out = 1'b0;
		cyc(3);
	endtask

	initial begin
		#400000;
		n_errors++;
		$display("BAD %0t run did not finish", $time);
		print_verdict();
	end

	initial begin
		void'($urandom(87));
		{rst_n, halt_exec, wake_req, ext_in, c50_out, cpu_clk_sel} = '0;
		c50_run = 1'b1;
		{hs_osc_run, int_osc_run, sub_osc_run} = 3'b111;
		tmh1_clk_sel = 3'h0;
		cnt51_clk_sel = `HMCG_CNT51_SEL_EXT;
		tmh0_clk_sel = `HMCG_TMH0_SEL_CNT50;
		cyc(2);
		rst_n = 1'b1;
		// Pause from each CPU clock source, with stray requests that must be ignored.
		for (int s = 0; s < 3; s++) begin
			cpu_clk_sel = s[1:0];
			wait_cpu(1100);
			wake_req = 1'b1;
			cyc(2);
			wake_req = 1'b0;
			halt_exec = 1'b1;
			q_halt.push_back(1'b1);
			cyc(2);
			halt_exec = 1'b0;
			base = n_cpu;
			base1 = n_tmh1;
			cyc(60);
			`TB_CHK(n_cpu, base, "CPU clock ran while paused")
			`TB_CHK(n_tmh1 >= base1 + 2, 1'b1, "timer stopped while paused")
			leave_halt();
			wait_cpu(1100);
		end
		// Guarantee flags over all selections with high speed stopped.
		enter_halt();
		hs_osc_run = 1'b0;
		for (int i = 0; i < 32; i++) begin
			t = (i < 16) ? i[2:0] : 3'($urandom);
			{tmh1_clk_sel, cnt51_clk_sel, tmh0_clk_sel} = {t, t, t};
			c50_run = (i < 16) ? i[3] : 1'($urandom);
			#1;
			`TB_CHK(tmh1_op_ok, 1'(t == `HMCG_TMH1_SEL_INT_DIV), "timer H1 guarantee")
			`TB_CHK(cnt51_op_ok, 1'(t == `HMCG_CNT51_SEL_EXT), "counter 51 guarantee")
			`TB_CHK(tmh0_op_ok, 1'(t == `HMCG_TMH0_SEL_CNT50 && c50_run), "timer H0 guarantee")
			cyc(1);
		end
		// External and counter 50 counting keeps going while paused.
		cnt51_clk_sel = `HMCG_CNT51_SEL_EXT;
		tmh0_clk_sel = `HMCG_TMH0_SEL_CNT50;
		tmh1_clk_sel = `HMCG_TMH1_SEL_INT_DIV;
		c50_run = 1'b1;
		cyc(2);
		base1 = n_tmh1;
		for (int k = 0; k < 3; k++) begin
			rise(2'd1);
			rise(2'd2);
		end
		`TB_CHK(q_pulse.size(), 0, "count pulse missing")
		cyc(520);
		`TB_CHK(n_tmh1 > base1, 1'b1, "timer H1 stopped on internal divided clock")
		hs_osc_run = 1'b1;
		#1;
		`TB_CHK({tmh1_op_ok, cnt51_op_ok, tmh0_op_ok}, 3'b111, "guarantee with high speed on")
		cyc(1);
		leave_halt();
		enter_halt();
		leave_halt();
		cyc(3);
		`TB_CHK(q_halt.size(), 0, "pause change missing")
		print_verdict();
	end
endmodule // tb_halt_mode_clock_gating

`default_nettype wire
